// >>> periph_side.sv
// peripheral and pad side model driving the multiplexer inputs
`default_nettype none
module periph_side (
  input wire logic clk_i,
  output logic [9:0] pin_o,
  output logic [9:0][7:0] fout_o,
  output logic [9:0][7:0] foe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt = 16'h0000;
  always_ff @(posedge clk_i)
  begin
    cnt <= cnt + 16'h0001;
  end
  // values move every cycle, but each check hangs on one input bit, so a stale route can still match by luck
  always_comb
  begin
    pin_o = cnt[9:0] ^ 10'h2a5;
    for (int p = 0; p < 10; p++)
    begin
      fout_o[p] = cnt[7:0] ^ 8'(p * 37);
      foe_o[p] = {cnt[2:0], cnt[7:3]} ^ 8'(p * 91);
    end
  end
endmodule
`default_nettype wire

// >>> pin_func_cell.sv
// one pin: decode of the select code into a single routed slot
`default_nettype none
module pin_func_cell #(
  parameter pin_func_pkg::slot_codes_t CODES = '0
) (
  input wire logic [pin_func_pkg::SEL_W-1:0] sel_i,
  input wire logic [pin_func_pkg::NUM_SLOTS-1:0] func_out_i,
  input wire logic [pin_func_pkg::NUM_SLOTS-1:0] func_oe_i,
  input wire logic pin_in_i,
  output logic next_out_o,
  output logic next_oe_o,
  output logic [pin_func_pkg::NUM_SLOTS-1:0] next_in_o,
  output logic legal_o
);
  // empty slots hold the hi-z code, so they can never match
  function automatic logic slot_hit(
    input logic [pin_func_pkg::SEL_W-1:0] sel,
    input logic [pin_func_pkg::SEL_W-1:0] code
  );
    slot_hit = (code != pin_func_pkg::FSEL_HIZ) && (sel == code);
  endfunction

  wire [pin_func_pkg::NUM_SLOTS-1:0] hit;

  genvar s;
  generate
    for (s = 0; s < pin_func_pkg::NUM_SLOTS; s++)
    begin : g_slot
      assign hit[s] = slot_hit(sel_i, CODES[s]);
      assign next_in_o[s] = hit[s] & pin_in_i;
    end
  endgenerate

  // codes are distinct per pin, so hit is one-hot or empty
  assign next_out_o = |(hit & func_out_i);
  assign next_oe_o = |(hit & func_oe_i);
  assign legal_o = |hit;
endmodule
`default_nettype wire

// >>> pin_func_mux.sv
// port 1 / port 2 pin function multiplexer with its select registers
// Overview of operation
// - A five-bit select code per pin; code zero disconnects every peripheral (hi-z).
// - Pin 1.2: code 05h routes timer 1 count clock in, code 0Fh the I2C clock line.
// - Pin 1.3: 01h multifunction timer ch0 B, 05h timer 3 output, 0Fh I2C data.
// - Pin 1.4: 0Bh serial 1 flow select, 10h CAN transmit, 19h touch 6, plus timers.
// - Pin 1.6: 07h clock out, 09h converter trigger, 0Dh SPI out, 0Fh I2C clock, 0Ah tx.
// - Pin 1.7: 07h output-enable input 8, 0Ah serial 1 clock, 0Dh SPI in, 0Fh I2C data.
// - Pin 2.0: 01h multifunction timer ch1 A, 05h timer 0 reset input.
// - Pin 2.1: 01h multifunction timer ch1 B, 05h timer 0 count clock input.
// - Pin 2.6: 01h ch2 A, 05h timer 1 out, 0Ah serial 1 tx, 19h touch 4, 1Bh low-power.
// - Pin 2.7: 01h ch2 B, 05h timer 3 count clock, 0Ah serial 1 clock, 19h touch 3.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`default_nettype none
module pin_func_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pin_func_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pin_func_pkg::DATA_W-1:0] wb_dat_i,
  output logic [pin_func_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [pin_func_pkg::NUM_PINS-1:0] pin_in_i,
  output logic [pin_func_pkg::NUM_PINS-1:0] pin_out_o,
  output logic [pin_func_pkg::NUM_PINS-1:0] pin_oe_o,
  input wire logic [pin_func_pkg::NUM_PINS-1:0][pin_func_pkg::NUM_SLOTS-1:0] func_out_i,
  input wire logic [pin_func_pkg::NUM_PINS-1:0][pin_func_pkg::NUM_SLOTS-1:0] func_oe_i,
  output logic [pin_func_pkg::NUM_PINS-1:0][pin_func_pkg::NUM_SLOTS-1:0] func_in_o
);
  logic [pin_func_pkg::SEL_W-1:0] psel [pin_func_pkg::NUM_PINS];
  logic [pin_func_pkg::SEL_W-1:0] rd_field;
  wire req;
  wire wr_fire;
  wire rd_start;
  wire [pin_func_pkg::NUM_PINS-1:0] reg_hit;
  wire [pin_func_pkg::NUM_PINS-1:0] next_out;
  wire [pin_func_pkg::NUM_PINS-1:0] next_oe;
  wire [pin_func_pkg::NUM_PINS-1:0] legal;
  wire [pin_func_pkg::NUM_PINS-1:0][pin_func_pkg::NUM_SLOTS-1:0] next_in;
  wire [pin_func_pkg::DATA_W-1:0] next_dat;

  assign req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where the master sees ack
  assign wr_fire = req & wb_ack_o & wb_we_i & wb_sel_i[pin_func_pkg::SEL_LANE];
  assign rd_start = req & ~wb_ack_o;

  // unmapped offsets still ack, reading zero and ignoring writes
  always_comb
  begin
    rd_field = pin_func_pkg::FSEL_HIZ;
    for (int i = 0; i < pin_func_pkg::NUM_PINS; i++)
    begin
      if (reg_hit[i])
      begin
        rd_field = psel[i];
      end
    end
  end
  // upper bits of each byte-wide register read as zero
  assign next_dat = pin_func_pkg::DATA_W'(rd_field);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= rd_start;
      wb_dat_o <= rd_start ? next_dat : '0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < pin_func_pkg::NUM_PINS; i++)
    begin : g_pin
      assign reg_hit[i] = (wb_adr_i == pin_func_pkg::REG_OFS[i]);

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          psel[i] <= pin_func_pkg::SEL_RESET;
        end
        else if (wr_fire && reg_hit[i])
        begin
          psel[i] <= wb_dat_i[pin_func_pkg::SEL_W-1:0];
        end
      end

      pin_func_cell #(
        .CODES(pin_func_pkg::SLOT_CODE[i])
      ) u_cell (
        .sel_i(psel[i]),
        .func_out_i(func_out_i[i]),
        .func_oe_i(func_oe_i[i]),
        .pin_in_i(pin_in_i[i]),
        .next_out_o(next_out[i]),
        .next_oe_o(next_oe[i]),
        .next_in_o(next_in[i]),
        .legal_o(legal[i])
      );

      // registered pin side costs one cycle of route latency
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pin_out_o[i] <= 1'b0;
          pin_oe_o[i] <= 1'b0;
          func_in_o[i] <= '0;
        end
        else
        begin
          pin_out_o[i] <= next_out[i];
          pin_oe_o[i] <= next_oe[i];
          func_in_o[i] <= next_in[i];
        end
      end

      a_zero_code_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        psel[i] == pin_func_pkg::FSEL_HIZ |=> !pin_oe_o[i] && func_in_o[i] == '0)
        else $error("hi-z code still drives pin");

      a_unused_code_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !legal[i] |=> !pin_oe_o[i] && !pin_out_o[i] && func_in_o[i] == '0)
        else $error("unassigned code routes a function");

      a_write_sets_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && reg_hit[i] |=> psel[i] == $past(wb_dat_i[pin_func_pkg::SEL_W-1:0]))
        else $error("select register missed a write");

      a_single_route: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot0(next_in[i]))
        else $error("more than one function routed");
    end
  endgenerate

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_read_returns_sel: assert property (
    rd_start && !wb_we_i && reg_hit[pin_func_pkg::P1_6] && !wr_fire
    |=> wb_ack_o && wb_dat_o == pin_func_pkg::DATA_W'($past(psel[pin_func_pkg::P1_6])))
    else $error("readback differs from select");

  a_ack_single_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_p12_i2c_clock: assert property (
    psel[pin_func_pkg::P1_2] == pin_func_pkg::FSEL_I2C
    |=> func_in_o[pin_func_pkg::P1_2][1] == $past(pin_in_i[pin_func_pkg::P1_2])
    && pin_oe_o[pin_func_pkg::P1_2] == $past(func_oe_i[pin_func_pkg::P1_2][1]))
    else $error("pin 1.2 clock line not routed");

  a_p13_i2c_data: assert property (
    psel[pin_func_pkg::P1_3] == pin_func_pkg::FSEL_I2C
    |=> pin_out_o[pin_func_pkg::P1_3] == $past(func_out_i[pin_func_pkg::P1_3][2]))
    else $error("pin 1.3 data line not routed");

  a_p14_can_tx: assert property (
    psel[pin_func_pkg::P1_4] == pin_func_pkg::FSEL_CAN
    |=> pin_out_o[pin_func_pkg::P1_4] == $past(func_out_i[pin_func_pkg::P1_4][4])
    && pin_oe_o[pin_func_pkg::P1_4] == $past(func_oe_i[pin_func_pkg::P1_4][4]))
    else $error("pin 1.4 transmit not routed");

  a_p15_can_rx: assert property (
    psel[pin_func_pkg::P1_5] == pin_func_pkg::FSEL_CAN
    |=> func_in_o[pin_func_pkg::P1_5][4] == $past(pin_in_i[pin_func_pkg::P1_5]))
    else $error("pin 1.5 receive not routed");

  a_p16_clock_out: assert property (
    psel[pin_func_pkg::P1_6] == pin_func_pkg::FSEL_MISC
    |=> pin_out_o[pin_func_pkg::P1_6] == $past(func_out_i[pin_func_pkg::P1_6][3]))
    else $error("pin 1.6 clock output not routed");

  a_p17_spi_in: assert property (
    psel[pin_func_pkg::P1_7] == pin_func_pkg::FSEL_SPI
    |=> func_in_o[pin_func_pkg::P1_7][5] == $past(pin_in_i[pin_func_pkg::P1_7]))
    else $error("pin 1.7 spi input not routed");

  a_p20_tmr_reset: assert property (
    psel[pin_func_pkg::P2_0] == pin_func_pkg::FSEL_TMR8
    |=> func_in_o[pin_func_pkg::P2_0][1] == $past(pin_in_i[pin_func_pkg::P2_0]))
    else $error("pin 2.0 timer reset not routed");

  a_p21_tmr_clock: assert property (
    psel[pin_func_pkg::P2_1] == pin_func_pkg::FSEL_TMR8
    |=> func_in_o[pin_func_pkg::P2_1][1] == $past(pin_in_i[pin_func_pkg::P2_1]))
    else $error("pin 2.1 timer clock not routed");

  a_p26_lpt_out: assert property (
    psel[pin_func_pkg::P2_6] == pin_func_pkg::FSEL_LPT
    |=> pin_out_o[pin_func_pkg::P2_6] == $past(func_out_i[pin_func_pkg::P2_6][4]))
    else $error("pin 2.6 low-power output not routed");

  a_p27_touch: assert property (
    psel[pin_func_pkg::P2_7] == pin_func_pkg::FSEL_TOUCH
    |=> pin_oe_o[pin_func_pkg::P2_7] == $past(func_oe_i[pin_func_pkg::P2_7][3]))
    else $error("pin 2.7 touch channel not routed");

  c_write_i2c: cover property (
    wr_fire && wb_dat_i[pin_func_pkg::SEL_W-1:0] == pin_func_pkg::FSEL_I2C);
  c_read_back: cover property (rd_start && !wb_we_i ##1 wb_ack_o);
  c_can_tx_live: cover property (pin_oe_o[pin_func_pkg::P1_4]);
  c_unused_code: cover property (!legal[pin_func_pkg::P2_0]);
endmodule
`default_nettype wire

// >>> pin_func_pkg.sv
// constants shared by the port 1 / port 2 pin function multiplexer
`default_nettype none
package pin_func_pkg;
  localparam int NUM_PINS = 10;
  localparam int NUM_SLOTS = 8;
  localparam int SEL_W = 5;
  localparam int REG_W = 8;
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int SEL_LANE = 0;

  // pin index order
  localparam int P1_2 = 0;
  localparam int P1_3 = 1;
  localparam int P1_4 = 2;
  localparam int P1_5 = 3;
  localparam int P1_6 = 4;
  localparam int P1_7 = 5;
  localparam int P2_0 = 6;
  localparam int P2_1 = 7;
  localparam int P2_6 = 8;
  localparam int P2_7 = 9;

  // register byte offsets, one aligned word each
  localparam logic [ADR_W-1:0] REG_OFS [NUM_PINS] = '{
    8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
    8'h14, 8'h18, 8'h1C, 8'h20, 8'h24
  };
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;

  // function select codes
  localparam logic [SEL_W-1:0] FSEL_HIZ = 5'h00;
  localparam logic [SEL_W-1:0] FSEL_MTMR = 5'h01;
  localparam logic [SEL_W-1:0] FSEL_MTMR2 = 5'h02;
  localparam logic [SEL_W-1:0] FSEL_TMR8 = 5'h05;
  localparam logic [SEL_W-1:0] FSEL_MISC = 5'h07;
  localparam logic [SEL_W-1:0] FSEL_ADTRG = 5'h09;
  localparam logic [SEL_W-1:0] FSEL_SER_A = 5'h0A;
  localparam logic [SEL_W-1:0] FSEL_SER_B = 5'h0B;
  localparam logic [SEL_W-1:0] FSEL_SPI = 5'h0D;
  localparam logic [SEL_W-1:0] FSEL_I2C = 5'h0F;
  localparam logic [SEL_W-1:0] FSEL_CAN = 5'h10;
  localparam logic [SEL_W-1:0] FSEL_TOUCH = 5'h19;
  localparam logic [SEL_W-1:0] FSEL_LPT = 5'h1B;

  // per pin: slot s answers to code SLOT_CODE[pin][s]; zero marks an empty slot
  typedef logic [0:NUM_SLOTS-1][SEL_W-1:0] slot_codes_t;
  localparam slot_codes_t SLOT_CODE [NUM_PINS] = '{
    '{FSEL_TMR8, FSEL_I2C, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_TMR8, FSEL_I2C, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_MTMR2, FSEL_TMR8, FSEL_SER_B, FSEL_CAN, FSEL_TOUCH,
      5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_MTMR2, FSEL_TMR8, FSEL_SER_A, FSEL_CAN, FSEL_TOUCH,
      5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_MTMR2, FSEL_TMR8, FSEL_MISC, FSEL_ADTRG, FSEL_SER_A,
      FSEL_SPI, FSEL_I2C},
    '{FSEL_MTMR, FSEL_MTMR2, FSEL_TMR8, FSEL_MISC, FSEL_SER_A, FSEL_SPI,
      FSEL_I2C, 5'h00},
    '{FSEL_MTMR, FSEL_TMR8, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_TMR8, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_TMR8, FSEL_SER_A, FSEL_TOUCH, FSEL_LPT,
      5'h00, 5'h00, 5'h00},
    '{FSEL_MTMR, FSEL_TMR8, FSEL_SER_A, FSEL_TOUCH, 5'h00, 5'h00, 5'h00, 5'h00}
  };
endpackage
`default_nettype wire

// >>> tb.sv
// self-checking bench for the pin function multiplexer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack;
  logic [9:0] pin_in, pout, poe, c_pin;
  logic [9:0][7:0] fout, foe, fin, c_fo, c_oe;
  int miscompares = 0;
  int comparisons = 0;
  localparam int NUM_ROWS = 47;
  // rows: pin, code, slot (8 = nothing routed)
  localparam int rows [NUM_ROWS][3] = '{
    '{0, 5'h05, 0}, '{0, 5'h0f, 1}, '{0, 5'h0a, 8},
    '{1, 5'h01, 0}, '{1, 5'h05, 1}, '{1, 5'h0f, 2},
    '{2, 5'h0b, 3}, '{2, 5'h10, 4}, '{2, 5'h19, 5}, '{2, 5'h01, 0}, '{2, 5'h02, 1},
    '{2, 5'h05, 2},
    '{3, 5'h0a, 3}, '{3, 5'h10, 4}, '{3, 5'h19, 5}, '{3, 5'h01, 0}, '{3, 5'h02, 1},
    '{3, 5'h05, 2},
    '{4, 5'h07, 3}, '{4, 5'h09, 4}, '{4, 5'h0d, 6}, '{4, 5'h0f, 7}, '{4, 5'h0a, 5},
    '{4, 5'h01, 0}, '{4, 5'h02, 1}, '{4, 5'h05, 2},
    '{5, 5'h07, 3}, '{5, 5'h0a, 4}, '{5, 5'h0d, 5}, '{5, 5'h0f, 6}, '{5, 5'h01, 0},
    '{5, 5'h02, 1}, '{5, 5'h05, 2},
    '{6, 5'h01, 0}, '{6, 5'h05, 1}, '{7, 5'h01, 0}, '{7, 5'h05, 1},
    '{8, 5'h01, 0}, '{8, 5'h05, 1}, '{8, 5'h0a, 2}, '{8, 5'h19, 3}, '{8, 5'h1b, 4},
    '{9, 5'h01, 0}, '{9, 5'h05, 1}, '{9, 5'h0a, 2}, '{9, 5'h19, 3}, '{9, 5'h00, 8}
  };
  always #20 clk_i = ~clk_i;
  periph_side peer (.clk_i(clk_i), .pin_o(pin_in), .fout_o(fout), .foe_o(foe));
  pin_func_mux dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe),
    .func_out_i(fout), .func_oe_i(foe), .func_in_o(fin));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // called just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic w, input int a, input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= 8'(a);
    wdat <= d;
    sel <= s;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = dat_o;
    if (n >= 20)
      miscompares++;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic route(input int p, input int s);
    @(negedge clk_i);
    c_pin = pin_in;
    c_fo = fout;
    c_oe = foe;
    @(negedge clk_i);
    chk("pin out", {31'h0, pout[p]}, {31'h0, (s < 8) ? c_fo[p][s] : 1'b0});
    chk("pin oe", {31'h0, poe[p]}, {31'h0, (s < 8) ? c_oe[p][s] : 1'b0});
    chk("func in", {24'h0, fin[p]}, (s < 8) ? 32'(c_pin[p]) << s : 32'h0000_0000);
    @(posedge clk_i);
  endtask
  task automatic all_clear(input string name);
    @(negedge clk_i);
    chk("oe idle", {22'h0, poe}, 32'h0000_0000);
    chk("out idle", {22'h0, pout}, 32'h0000_0000);
    chk("fin idle", {31'h0, |fin}, 32'h0000_0000);
    @(posedge clk_i);
    for (int p = 0; p < 10; p++)
    begin
      bus(1'b0, p * 4, 32'h0000_0000, 4'h0);
      chk("reset value", rd, 32'h0000_0000);
    end
    $display("test %s done", name);
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    all_clear("reset");
    for (int i = 0; i < NUM_ROWS; i++)
    begin
      bus(1'b1, rows[i][0] * 4, 32'(rows[i][1]), 4'h1);
      bus(1'b0, rows[i][0] * 4, 32'h0000_0000, 4'h0);
      chk("readback", rd, 32'(rows[i][1]));
      route(rows[i][0], rows[i][2]);
    end
    $display("test table done");
    // upper bits dropped, unselected byte lane ignored, unmapped place inert
    bus(1'b1, 0, 32'hffff_ffef, 4'hf);
    bus(1'b1, 0, 32'h0000_0005, 4'he);
    bus(1'b1, 40, 32'h0000_001f, 4'hf);
    bus(1'b0, 0, 32'h0000_0000, 4'h0);
    chk("masked write", rd, 32'h0000_000f);
    bus(1'b0, 40, 32'h0000_0000, 4'h0);
    chk("unmapped read", rd, 32'h0000_0000);
    route(0, 1);
    bus(1'b1, 16, 32'h0000_0000, 4'h1);
    route(4, 8);
    $display("test awkward done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    all_clear("second reset");
    finish_test();
  end
endmodule
`default_nettype wire
